// ===== dv/hrcwd_src_model.sv
/* Far-side model of the reset configuration source on the data pins.
   Assumes the bench drives hard_reset_n and the word to present. */
`timescale 1ns/10ps
module hrcwd_src_model (
    // Clock and hard reset seen by the source
    input  wire logic        clk_sys,
    input  wire logic        hard_reset_n,
    // Word to present, and the pins themselves
    input  wire logic [0:31] word,
    output logic      [0:31] data_pins
);
    int hold_cnt = 0;
    initial data_pins = 32'h0000_0000;
    // Word held through release plus setup; later the pins carry other
    // traffic, so they flip every cycle instead of keeping the last value
    always @(negedge clk_sys) begin
        if (!hard_reset_n) begin
            hold_cnt = 0;
            data_pins <= word & 32'hffff_feff;
        end else if (hold_cnt < 8) begin
            hold_cnt = hold_cnt + 1;
        end else begin
            data_pins <= ~data_pins;
        end
    end
endmodule : hrcwd_src_model

// ===== dv/hrcwd_top_tb.sv
/* Self-checking bench of the configuration word decoder top.
   Assumes the source model and the design files are compiled first. */
`timescale 1ns/10ps
module hrcwd_top_tb;
    import hrcwd_pkg::*;
    logic clk_sys = 0, rstn = 0, hard_reset_n = 0, soft_reset_n = 1;
    logic strobe_n = 1, flag = 0, b0_wr = 0;
    logic [0:31] pin_word = 0, flash = 0, pins;
    wire  [24:0] obs;
    int n_fail = 0, n_compared = 0;
    // ************************************************************
    // Clock, source model and design
    // ************************************************************
    always #20 clk_sys = ~clk_sys;
    hrcwd_src_model src (.clk_sys(clk_sys), .hard_reset_n(hard_reset_n),
        .word(pin_word), .data_pins(pins));
    hrcwd_top dut (.clk_sys(clk_sys), .rstn(rstn),
        .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n),
        .config_strobe_n(strobe_n), .data_pins(pins),
        .has_config_flag(flag), .flash_config_word(flash),
        .bank0_option_written(b0_wr), .config_valid(obs[24]),
        .config_source(obs[23:22]), .reserved_bit_error(obs[21]),
        .dev_port_reinit(), .external_boot_disable(obs[20]),
        .bank0_active(obs[19]), .bank0_match_all(obs[18]),
        .boot_port_width(obs[17:16]), .boot_port_reserved(obs[15]),
        .boot_port_override(), .debug_port_pin_select(obs[14]),
        .addr_type_wren_pin_select(obs[13]),
        .ext_bus_clock_divider(obs[12:11]),
        .peripheral_mode_enable(obs[10]),
        .chip_bus_mode_select(obs[9:8]),
        .exc_table_relocate_enable(obs[7]), .onchip_nvm_enable(obs[6]),
        .compressed_code_enable(obs[5]), .compressed_handlers_flag(obs[4]),
        .internal_map_base_select(obs[3:1]), .nvm_dual_map_enable(obs[0]));
    // ************************************************************
    // Expectation and comparison
    // ************************************************************
    // Every output but dev_port_reinit and boot_port_override, derived from the word, the source and the override
    function automatic logic [24:0] exp_of(logic [0:31] w, logic [1:0] s,
                                          logic ovr);
        return {1'b1, s, w[23], w[3], ~w[3], ~w[3] & ~ovr, w[4], w[5],
            w[4] & w[5], w[11], w[12], w[13], w[14], w[16], w[17], w[18],
            w[19], w[20], w[21], w[22], w[28], w[29], w[30], w[31]};
    endfunction : exp_of
    task automatic chk(logic [24:0] got, logic [24:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    // ************************************************************
    // Scenarios
    // ************************************************************
    // Hard reset with the chosen source, then check every setting
    task automatic capture(logic [0:31] w, logic sn, logic fl, logic [1:0] s);
        int i;
        @(negedge clk_sys);
        hard_reset_n = 0;
        strobe_n = sn;
        flag = fl;
        pin_word = sn ? ~w : w;
        flash = sn ? w : ~w & 32'hffff_feff;
        repeat (4) @(negedge clk_sys);
        chk({24'h0, obs[24]}, 25'h0);
        hard_reset_n = 1;
        for (i = 0; i < 10 && obs[24] !== 1'b1; i++) @(negedge clk_sys);
        chk({24'h0, dut.dev_port_reinit}, 25'h1);
        chk(obs, exp_of((sn & fl) ? 32'h0 : w, s, 1'b0));
    endtask : capture
    // Sources change after capture, soft reset pulses: nothing resampled
    task automatic hold_and_soft(logic [0:31] w, logic [1:0] s);
        int i;
        strobe_n = ~strobe_n;
        flag = ~flag;
        flash = ~flash;
        soft_reset_n = 0;
        repeat (12) @(negedge clk_sys);
        soft_reset_n = 1;
        for (i = 0; i < 8 && dut.dev_port_reinit !== 1'b1; i++)
            @(negedge clk_sys);
        chk({24'h0, dut.dev_port_reinit}, 25'h1);
        @(negedge clk_sys);
        chk({24'h0, dut.dev_port_reinit}, 25'h0);
        chk(obs, exp_of(w, s, 1'b0));
    endtask : hold_and_soft
    // Bank-0 option write drops the match-all boot decode
    task automatic option_write(logic [0:31] w, logic [1:0] s);
        b0_wr = 1;
        @(negedge clk_sys);
        b0_wr = 0;
        @(negedge clk_sys);
        chk({24'h0, dut.boot_port_override}, 25'h1);
        chk(obs, exp_of(w, s, 1'b1));
    endtask : option_write
    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        logic [0:31] pat [4] = '{32'hffff_ffff, 32'h0, 32'ha5a5_a5a5,
                                 32'h5a5a_5a5a};
        logic [0:31] w;
        logic        fl;
        repeat (20) @(negedge clk_sys);
        rstn = 1;
        for (int k = 0; k < 4; k++) begin
            w = pat[k];
            w[4:5] = k[1:0];
            w[13:14] = k[1:0];
            w[17:18] = k[1:0];
            w[23] = 1'b0;
            // Flag raised with strobe low once: the pins must still win
            fl = ~k[0] & k[1];
            capture(w, k[0], fl, k[0] ? 2'h1 : 2'h0);
            hold_and_soft(w, k[0] ? 2'h1 : 2'h0);
            if (!w[3]) option_write(w, k[0] ? 2'h1 : 2'h0);
        end
        capture(32'hffff_feff, 1'b1, 1'b1, 2'h2);
        end_sim();
    end
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
endmodule : hrcwd_top_tb

// ===== pkg/hrcwd_cfg_if.sv
/*
 * Carrier between the capture core and the field decoder: the captured
 * word one way, the decoded settings the other.
 * Assumes hrcwd_pkg is compiled first.
 */
`timescale 1ns/10ps
interface hrcwd_cfg_if;
    logic [0:31]         word;
    hrcwd_pkg::hrcwd_cfg_s cfg;

    modport core (output word, input cfg);
    modport dec  (input word, output cfg);
endinterface : hrcwd_cfg_if

// ===== pkg/hrcwd_defs.svh
/*
 * Constants of the hard reset configuration word decoder: bit positions
 * of every field in the captured word, encodings and reset values.
 * Assumes the word is indexed [0:31] with bit 0 as the most significant
 * bit, so every position below matches the printed numbering.
 */
`ifndef HRCWD_DEFS_SVH
`define HRCWD_DEFS_SVH

// ********************************************************************
// Word layout
// ********************************************************************
`define HRCWD_WORD_W          32
`define HRCWD_POS_BOOT_OFF    3
`define HRCWD_POS_PORT_LO     4
`define HRCWD_POS_PORT_HI     5
`define HRCWD_POS_DBG_PINS    11
`define HRCWD_POS_WREN_PINS   12
`define HRCWD_POS_CLKDIV_LO   13
`define HRCWD_POS_CLKDIV_HI   14
`define HRCWD_POS_PERIPH      16
`define HRCWD_POS_MODE_LO     17
`define HRCWD_POS_MODE_HI     18
`define HRCWD_POS_RELOC       19
`define HRCWD_POS_NVM         20
`define HRCWD_POS_CMPR        21
`define HRCWD_POS_CMPR_HDL    22
`define HRCWD_POS_MUST_LOW    23
`define HRCWD_POS_BASE_LO     28
`define HRCWD_POS_BASE_HI     30
`define HRCWD_POS_DUAL        31

// ********************************************************************
// Encodings and reset values
// ********************************************************************
`define HRCWD_DEFAULT_WORD    32'h0000_0000
`define HRCWD_PORT_32         2'h0
`define HRCWD_PORT_8          2'h1
`define HRCWD_PORT_16         2'h2
`define HRCWD_PORT_RSVD       2'h3
`define HRCWD_SYNC_RST        1'h0

`endif

// ===== pkg/hrcwd_pkg.sv
/*
 * Types of the hard reset configuration word decoder.
 * Assumes hrcwd_defs.svh is on the include path.
 */
package hrcwd_pkg;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    // Declared in field order so a cast of the raw field is exact
    typedef enum logic [1:0] {
        HRCWD_EXT_32,
        HRCWD_EXT_16,
        HRCWD_SINGLE_SHOW,
        HRCWD_SINGLE
    } hrcwd_bus_mode_e;

    typedef enum logic [1:0] {
        HRCWD_SRC_PINS,
        HRCWD_SRC_FLASH,
        HRCWD_SRC_ZERO
    } hrcwd_src_e;

    typedef enum {
        HRCWD_ST_RESET,
        HRCWD_ST_LOAD,
        HRCWD_ST_HOLD
    } hrcwd_state_e;

    // ****************************************************************
    // Decoded settings; all zero is the documented default
    // ****************************************************************
    typedef struct packed {
        logic            debug_pin_fn;
        logic            addr_wren_fn;
        logic [1:0]      bus_clk_div;
        logic            periph_mode;
        hrcwd_bus_mode_e bus_mode;
        logic            exc_reloc;
        logic            nvm_en;
        logic            cmpr_en;
        logic            cmpr_handlers;
        logic [2:0]      map_base;
        logic            dual_map;
        logic [1:0]      port_width;
        logic            port_rsvd;
        logic            boot_off;
        logic            must_low_err;
    } hrcwd_cfg_s;

endpackage : hrcwd_pkg

// ===== src/hrcwd_top.sv
/*
 * Hard reset configuration word decoder, top level. Synchronises the
 * reset and strap pins, picks the word source, captures the word at the
 * release of hard reset and holds the decoded settings until the next
 * hard reset. Soft reset only pulses the development port re-init.
 * Assumes one 25 MHz clock, synchronous active-low rstn, and that the
 * flash word and has-config flag are stable logic on this clock.
 */
`timescale 1ns/10ps
`include "hrcwd_defs.svh"
module hrcwd_top (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rstn,
    // Pins from outside the clock domain
    input  wire logic                     hard_reset_n,
    input  wire logic                     soft_reset_n,
    input  wire logic                     config_strobe_n,
    input  wire logic [0:31]              data_pins,
    // On-chip sources
    input  wire logic                     has_config_flag,
    input  wire logic [0:31]              flash_config_word,
    input  wire logic                     bank0_option_written,
    // Status
    output logic                          config_valid,
    output hrcwd_pkg::hrcwd_src_e         config_source,
    output logic                          reserved_bit_error,
    output logic                          dev_port_reinit,
    // Memory controller boot settings
    output logic                          external_boot_disable,
    output logic                          bank0_active,
    output logic                          bank0_match_all,
    output logic [1:0]                    boot_port_width,
    output logic                          boot_port_reserved,
    output logic                          boot_port_override,
    // Chip-level settings
    output logic                          debug_port_pin_select,
    output logic                          addr_type_wren_pin_select,
    output logic [1:0]                    ext_bus_clock_divider,
    output logic                          peripheral_mode_enable,
    output hrcwd_pkg::hrcwd_bus_mode_e    chip_bus_mode_select,
    output logic                          exc_table_relocate_enable,
    output logic                          onchip_nvm_enable,
    output logic                          compressed_code_enable,
    output logic                          compressed_handlers_flag,
    output logic [2:0]                    internal_map_base_select,
    output logic                          nvm_dual_map_enable
);
    import hrcwd_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    hrcwd_cfg_if    dec_bus ();

    logic           hr_s1_ff,  nxt_hr_s1;
    logic           hr_s2_ff,  nxt_hr_s2;
    logic           hr_d_ff,   nxt_hr_d;
    logic           sr_s1_ff,  nxt_sr_s1;
    logic           sr_s2_ff,  nxt_sr_s2;
    logic           sr_d_ff,   nxt_sr_d;
    logic           cs_s1_ff,  nxt_cs_s1;
    logic           cs_s2_ff,  nxt_cs_s2;
    logic [0:31]    dp_s1_ff,  nxt_dp_s1;
    logic [0:31]    dp_s2_ff,  nxt_dp_s2;

    hrcwd_state_e   state_ff,  nxt_state;
    logic [0:31]    word_ff,   nxt_word;
    hrcwd_src_e     src_ff,    nxt_src;
    hrcwd_cfg_s     cfg_ff,    nxt_cfg;
    logic           valid_ff,  nxt_valid;
    logic           ovr_ff,    nxt_ovr;
    logic           reinit_ff, nxt_reinit;

    logic           hr_rise;
    logic           sr_rise;
    logic [0:31]    sel_word;
    hrcwd_src_e     sel_src;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Two flops per pin; the extra delayed copies feed the edge
    // detectors so that nothing ever looks at a first stage
    always_comb begin
        nxt_hr_s1 = hard_reset_n;
        nxt_hr_s2 = hr_s1_ff;
        nxt_hr_d  = hr_s2_ff;
        nxt_sr_s1 = soft_reset_n;
        nxt_sr_s2 = sr_s1_ff;
        nxt_sr_d  = sr_s2_ff;
        nxt_cs_s1 = config_strobe_n;
        nxt_cs_s2 = cs_s1_ff;
        nxt_dp_s1 = data_pins;
        nxt_dp_s2 = dp_s1_ff;
    end

    // Resets show hard reset as asserted, so a release is always seen
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            hr_s1_ff <= `HRCWD_SYNC_RST;
            hr_s2_ff <= `HRCWD_SYNC_RST;
            hr_d_ff  <= `HRCWD_SYNC_RST;
            sr_s1_ff <= `HRCWD_SYNC_RST;
            sr_s2_ff <= `HRCWD_SYNC_RST;
            sr_d_ff  <= `HRCWD_SYNC_RST;
            cs_s1_ff <= `HRCWD_SYNC_RST;
            cs_s2_ff <= `HRCWD_SYNC_RST;
            dp_s1_ff <= `HRCWD_DEFAULT_WORD;
            dp_s2_ff <= `HRCWD_DEFAULT_WORD;
        end else begin
            hr_s1_ff <= nxt_hr_s1;
            hr_s2_ff <= nxt_hr_s2;
            hr_d_ff  <= nxt_hr_d;
            sr_s1_ff <= nxt_sr_s1;
            sr_s2_ff <= nxt_sr_s2;
            sr_d_ff  <= nxt_sr_d;
            cs_s1_ff <= nxt_cs_s1;
            cs_s2_ff <= nxt_cs_s2;
            dp_s1_ff <= nxt_dp_s1;
            dp_s2_ff <= nxt_dp_s2;
        end
    end

    // ****************************************************************
    // Release detection and source choice
    // ****************************************************************
    // Data pins pass as many stages as hard reset, so the word seen in
    // the release cycle is the one present at the pin edge
    assign hr_rise = hr_s2_ff & ~hr_d_ff;
    assign sr_rise = sr_s2_ff & ~sr_d_ff;

    always_comb begin
        if (!cs_s2_ff) begin
            sel_word = dp_s2_ff;
            sel_src  = HRCWD_SRC_PINS;
        end else if (!has_config_flag) begin
            sel_word = flash_config_word;
            sel_src  = HRCWD_SRC_FLASH;
        end else begin
            sel_word = `HRCWD_DEFAULT_WORD;
            sel_src  = HRCWD_SRC_ZERO;
        end
    end

    // ****************************************************************
    // Capture and hold sequencer
    // ****************************************************************
    // Any sight of hard reset low drops back to defaults; otherwise the
    // settings are frozen, whatever the pins do afterwards
    always_comb begin
        nxt_state  = state_ff;
        nxt_word   = word_ff;
        nxt_src    = src_ff;
        nxt_cfg    = cfg_ff;
        nxt_valid  = valid_ff;
        nxt_ovr    = ovr_ff;
        nxt_reinit = 1'b0;
        if (!hr_s2_ff) begin
            nxt_state = HRCWD_ST_RESET;
            nxt_cfg   = '0;
            nxt_valid = 1'b0;
            nxt_ovr   = 1'b0;
        end else begin
            case (state_ff)
                HRCWD_ST_RESET: begin
                    if (hr_rise) begin
                        nxt_word  = sel_word;
                        nxt_src   = sel_src;
                        nxt_state = HRCWD_ST_LOAD;
                    end
                end
                HRCWD_ST_LOAD: begin
                    nxt_cfg    = dec_bus.cfg;
                    nxt_valid  = 1'b1;
                    nxt_reinit = 1'b1;
                    nxt_state  = HRCWD_ST_HOLD;
                end
                HRCWD_ST_HOLD: begin
                    nxt_reinit = sr_rise;
                end
                default: begin
                    nxt_state = HRCWD_ST_RESET;
                end
            endcase
            // Sticky until the next hard reset; a write sets it only while hard reset is seen high
            if (bank0_option_written) begin
                nxt_ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff  <= HRCWD_ST_RESET;
            word_ff   <= `HRCWD_DEFAULT_WORD;
            src_ff    <= HRCWD_SRC_PINS;
            cfg_ff    <= '0;
            valid_ff  <= 1'b0;
            ovr_ff    <= 1'b0;
            reinit_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            word_ff   <= nxt_word;
            src_ff    <= nxt_src;
            cfg_ff    <= nxt_cfg;
            valid_ff  <= nxt_valid;
            ovr_ff    <= nxt_ovr;
            reinit_ff <= nxt_reinit;
        end
    end

    // ****************************************************************
    // Field decoder
    // ****************************************************************
    assign dec_bus.word = word_ff;

    hrcwd_word_decode u_decode (
        .bus (dec_bus)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The boot port field only matters until software owns bank 0
    assign config_valid              = valid_ff;
    assign config_source             = src_ff;
    assign reserved_bit_error        = cfg_ff.must_low_err;
    assign dev_port_reinit           = reinit_ff;
    assign external_boot_disable     = cfg_ff.boot_off;
    assign bank0_active              = valid_ff & ~cfg_ff.boot_off;
    assign bank0_match_all           = bank0_active & ~ovr_ff;
    assign boot_port_width           = cfg_ff.port_width;
    assign boot_port_reserved        = cfg_ff.port_rsvd;
    assign boot_port_override        = ovr_ff;
    assign debug_port_pin_select     = cfg_ff.debug_pin_fn;
    assign addr_type_wren_pin_select = cfg_ff.addr_wren_fn;
    assign ext_bus_clock_divider     = cfg_ff.bus_clk_div;
    assign peripheral_mode_enable    = cfg_ff.periph_mode;
    assign chip_bus_mode_select      = cfg_ff.bus_mode;
    assign exc_table_relocate_enable = cfg_ff.exc_reloc;
    assign onchip_nvm_enable         = cfg_ff.nvm_en;
    assign compressed_code_enable    = cfg_ff.cmpr_en;
    assign compressed_handlers_flag  = cfg_ff.cmpr_handlers;
    assign internal_map_base_select  = cfg_ff.map_base;
    assign nvm_dual_map_enable       = cfg_ff.dual_map;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_capture_timing;
        @(posedge clk_sys) disable iff (!rstn)
        (hr_rise && state_ff == HRCWD_ST_RESET)
            |=> (state_ff == HRCWD_ST_LOAD) ##1 (valid_ff && hr_s2_ff);
    endproperty
    a_capture_timing: assert property (p_capture_timing)
        else $error("settings not valid two cycles after release");

    property p_src_pins;
        @(posedge clk_sys) disable iff (!rstn)
        (hr_rise && state_ff == HRCWD_ST_RESET && !cs_s2_ff)
            |=> (word_ff == $past(dp_s2_ff)) && src_ff == HRCWD_SRC_PINS;
    endproperty
    a_src_pins: assert property (p_src_pins)
        else $error("pin word not captured with strobe low");

    property p_src_flash_zero;
        @(posedge clk_sys) disable iff (!rstn)
        (hr_rise && state_ff == HRCWD_ST_RESET && cs_s2_ff)
            |=> word_ff == ($past(has_config_flag) ?
                            `HRCWD_DEFAULT_WORD : $past(flash_config_word));
    endproperty
    a_src_flash_zero: assert property (p_src_flash_zero)
        else $error("flash or zero word not chosen with strobe high");

    property p_hold_steady;
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff == HRCWD_ST_HOLD && hr_s2_ff)
            |=> $stable(cfg_ff) && $stable(word_ff);
    endproperty
    a_hold_steady: assert property (p_hold_steady)
        else $error("settings changed outside hard reset");

    property p_defaults_in_reset;
        @(posedge clk_sys) disable iff (!rstn)
        !hr_s2_ff |=> (cfg_ff == '0) && !valid_ff && !ovr_ff;
    endproperty
    a_defaults_in_reset: assert property (p_defaults_in_reset)
        else $error("defaults not shown during hard reset");

    property p_soft_reinit;
        @(posedge clk_sys) disable iff (!rstn)
        (sr_rise && hr_s2_ff && state_ff == HRCWD_ST_HOLD)
            |=> reinit_ff && $stable(word_ff) && $stable(cfg_ff);
    endproperty
    a_soft_reinit: assert property (p_soft_reinit)
        else $error("soft reset disturbed the captured settings");

    property p_override;
        @(posedge clk_sys) disable iff (!rstn)
        (bank0_option_written && hr_s2_ff)
            |=> ovr_ff && !bank0_match_all;
    endproperty
    a_override: assert property (p_override)
        else $error("bank-0 option write did not override boot field");

    property p_bus_mode;
        @(posedge clk_sys) disable iff (!rstn)
        valid_ff |-> chip_bus_mode_select == hrcwd_bus_mode_e'(
            word_ff[`HRCWD_POS_MODE_LO:`HRCWD_POS_MODE_HI]);
    endproperty
    a_bus_mode: assert property (p_bus_mode)
        else $error("bus mode does not match captured word");

    property p_nvm_boot;
        @(posedge clk_sys) disable iff (!rstn)
        valid_ff |-> (onchip_nvm_enable == word_ff[`HRCWD_POS_NVM])
            && (bank0_active == !word_ff[`HRCWD_POS_BOOT_OFF]);
    endproperty
    a_nvm_boot: assert property (p_nvm_boot)
        else $error("flash enable or bank 0 active wrong");

endmodule : hrcwd_top

// ===== src/hrcwd_word_decode.sv
/*
 * Pure field decoder: splits the captured configuration word into the
 * initial chip-level settings.
 * Assumes the word is bit 0 = MSB and is stable while it is read.
 */
`timescale 1ns/10ps
`include "hrcwd_defs.svh"
module hrcwd_word_decode (
    // Word in, settings out
    hrcwd_cfg_if.dec bus
);
    import hrcwd_pkg::*;

    // ****************************************************************
    // Field split
    // ****************************************************************
    // Reserved positions 6-10, 15 and 24-27 are never looked at
    always_comb begin
        bus.cfg               = '0;
        bus.cfg.boot_off      = bus.word[`HRCWD_POS_BOOT_OFF];
        bus.cfg.port_width    = bus.word[`HRCWD_POS_PORT_LO:
                                         `HRCWD_POS_PORT_HI];
        bus.cfg.port_rsvd     = (bus.cfg.port_width == `HRCWD_PORT_RSVD);
        bus.cfg.debug_pin_fn  = bus.word[`HRCWD_POS_DBG_PINS];
        bus.cfg.addr_wren_fn  = bus.word[`HRCWD_POS_WREN_PINS];
        bus.cfg.bus_clk_div   = bus.word[`HRCWD_POS_CLKDIV_LO:
                                         `HRCWD_POS_CLKDIV_HI];
        bus.cfg.periph_mode   = bus.word[`HRCWD_POS_PERIPH];
        bus.cfg.bus_mode      = hrcwd_bus_mode_e'(
                                bus.word[`HRCWD_POS_MODE_LO:
                                         `HRCWD_POS_MODE_HI]);
        bus.cfg.exc_reloc     = bus.word[`HRCWD_POS_RELOC];
        bus.cfg.nvm_en        = bus.word[`HRCWD_POS_NVM];
        bus.cfg.cmpr_en       = bus.word[`HRCWD_POS_CMPR];
        bus.cfg.cmpr_handlers = bus.word[`HRCWD_POS_CMPR_HDL];
        // Flagged, not corrected: a high bit here is a source fault
        bus.cfg.must_low_err  = bus.word[`HRCWD_POS_MUST_LOW];
        bus.cfg.map_base      = bus.word[`HRCWD_POS_BASE_LO:
                                         `HRCWD_POS_BASE_HI];
        bus.cfg.dual_map      = bus.word[`HRCWD_POS_DUAL];
    end

endmodule : hrcwd_word_decode
